/* ccr_card_regs.v */
/*
 * Card configuration registers (config/status, pin replacement,
 * socket/copy) and the byte-lane steering of the I/O transfer path.
 * Assumes the option register block supplies config_index, the task file
 * supplies interrupt, command and read data, and the socket pins are
 * asynchronous to clk and held stable around each strobe.
 */
`default_nettype none
`include "ccr_defs.vh"

// Summary of operation
// (RQ1) Config index zero means memory mapped; every I/O cycle is ignored.
// (RQ2) Config/status register at 02h; bit order fixed; D7, D1, D0 written zero.
// (RQ3) Changed bit reads one while either change latch is set.
// (RQ4) In I/O mode status change pin low when changed and enabled, else high.
// (RQ5) Byte I/O select is stored but ignored; 8 and 16 bit I/O both accepted.
// (RQ6) Power level 1 disable resets to zero; fixed zero when level 1 unsupported.
// (RQ7) Low power request change makes ready busy until the new state is reached.
// (RQ8) Card powers down when idle and wakes when a command arrives.
// (RQ9) Interrupt bit shows internal request, reads zero while interrupts disabled.
// (RQ10) Pin replacement at 04h; D7,D6 read zero, D3,D2 read one.
// (RQ11) Ready or write-protect toggles set their change latches.
// (RQ12) Pin replacement D1 reads the internal ready state.
// (RQ13) Pin replacement D0 always reads zero.
// (RQ14) Change latch takes written value only when its mask bit is one.
// (RQ15) Socket/copy at 06h; drive bit reads as written, exported for compare.
// (RQ16) Socket number nibble is ignored and reads zero.
// (RQ17) Host writes socket/copy before config index, drive bits recommended zero.
// (RQ18) Host writes zero to socket/copy bit D7.
// (RQ19) I/O width strobe asserted for every I/O address answered.
// (RQ20) Without the width strobe the host splits words into two byte accesses.
// (RQ21) Wait asserted at start of input cycle until data is ready.
// (RQ22) Byte lane steering with one enable; register pin high inhibits I/O.
// (RQ23) Word I/O uses both lanes; odd-only access uses high lane alone.
// (RQ24) Registers decoded relative to attribute base 200h.
// (RQ25) Attribute accesses are byte wide at even addresses only.
module ccr_card_regs #(
   parameter IDLE_CYCLES  = `CCR_IDLE_CYC,
   parameter PL1_SUPPORT  = 0
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Socket strobes and address
   input  wire        reg_n,
   input  wire        ce1_n,
   input  wire        ce2_n,
   input  wire        oe_n,
   input  wire        we_n,
   input  wire        iord_n,
   input  wire        iowr_n,
   input  wire [10:0] addr,
   // Socket data, split by byte lane
   input  wire [15:0] data_in,
   output reg  [15:0] data_out,
   output reg  [1:0]  data_oe_n,
   // Socket status pins
   output reg         iois16_n,
   output reg         wait_n,
   output reg         status_change_pin,
   output reg         ready_irq_pin,
   // Internal side
   input  wire [5:0]  config_index,
   input  wire        irq_request,
   input  wire        irq_enable_n,
   input  wire        cmd_arrive,
   input  wire        io_data_ready,
   input  wire [7:0]  io_even_rdata,
   input  wire [7:0]  io_odd_rdata,
   output reg         io_rd_even,
   output reg         io_rd_odd,
   output reg         io_wr_even,
   output reg         io_wr_odd,
   output reg  [7:0]  io_wr_even_data,
   output reg  [7:0]  io_wr_odd_data,
   output reg         drive_select_bit,
   output reg         power_down
);

   localparam PS_ACTIVE  = 2'b00;
   localparam PS_TO_DOWN = 2'b01;
   localparam PS_DOWN    = 2'b10;
   localparam PS_TO_UP   = 2'b11;
   localparam SETTLE     = `CCR_SETTLE_CYC;
   localparam [31:0] SETTLE_W = SETTLE;
   localparam [31:0] IDLE_W   = IDLE_CYCLES;

   wire [6:0]  strb_s;
   wire [10:0] addr_s;
   wire [15:0] data_s;
   reg  [6:0]  strb_d;

   ccr_sync #(
      .WIDTH (7),
      .INIT  (`CCR_STROBES_IDLE)
   ) u_sync_strb (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({reg_n, ce2_n, ce1_n, oe_n, we_n, iord_n, iowr_n}),
      .sync_out (strb_s)
   );

   ccr_sync #(
      .WIDTH (27),
      .INIT  (27'h0)
   ) u_sync_bus (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({addr, data_in}),
      .sync_out ({addr_s, data_s})
   );

   wire s_reg_n  = strb_s[6];
   wire s_ce2_n  = strb_s[5];
   wire s_ce1_n  = strb_s[4];
   wire s_oe_n   = strb_s[3];
   wire s_we_n   = strb_s[2];
   wire s_iord_n = strb_s[1];
   wire s_iowr_n = strb_s[0];

   // Register state
   reg        sig_chg_en;
   reg        byte_io_sel;
   reg        pl1_disable;
   reg        audio_en;
   reg        low_power_request;
   reg        ready_change_latch;
   reg        wp_change_latch;
   reg        drive_num;
   reg [1:0]  pstate;
   reg [31:0] ptimer;
   reg        ready_q;
   reg        wp_q;

   wire wp_live_state    = 1'b0;
   wire ready_live_state = (pstate == PS_ACTIVE) || (pstate == PS_DOWN);
   wire io_mode          = (config_index != `CCR_RST_INDEX);  // RQ1
   wire changed          = ready_change_latch | wp_change_latch;  // RQ3
   wire irq_state        = irq_request & ~irq_enable_n;  // RQ9

   // Attribute decode: base 200h, even address, byte on low lane
   wire attr_sel = !s_reg_n && !s_ce1_n && (addr_s[10:4] == `CCR_BASE_HI)
                   && !addr_s[0];  // RQ24 RQ25
   wire [3:0] off = addr_s[3:0];
   wire attr_wr  = attr_sel && s_we_n && !strb_d[2] && strb_d[6] == 1'b0;
   wire attr_rd  = attr_sel && !s_oe_n;

   // I/O decode; register pin high inhibits I/O
   wire io_sel   = io_mode && !s_reg_n && !(s_ce1_n && s_ce2_n);  // RQ1 RQ22
   wire io_rd    = io_sel && !s_iord_n;
   wire io_wr_end = io_sel && s_iowr_n && !strb_d[0];
   wire io_rd_start = io_sel && !s_iord_n && strb_d[1];
   wire lane_lo  = !s_ce1_n;
   wire lane_hi  = !s_ce2_n;
   // Single enable with A0 high moves the odd byte on the low lane
   wire lo_odd   = !s_ce1_n && s_ce2_n && addr_s[0];  // RQ22

   wire [7:0] ccsr_rd = {changed, sig_chg_en, byte_io_sel, pl1_disable,
                         audio_en, low_power_request, irq_state, 1'b0};  // RQ2
   wire [7:0] prr_rd  = {2'b00, ready_change_latch, wp_change_latch,
                         `CCR_PR_FIXED_ONES, ready_live_state, 1'b0};  // RQ10 RQ12 RQ13
   wire [7:0] scr_rd  = {3'b000, drive_num, 4'h0};  // RQ15 RQ16

   reg [7:0] attr_rdata;
   always @*
   begin
      case (off)
         `CCR_OFF_CCSR: attr_rdata = ccsr_rd;
         `CCR_OFF_PRR:  attr_rdata = prr_rd;
         `CCR_OFF_SCR:  attr_rdata = scr_rd;
         default:       attr_rdata = `CCR_RST_BYTE;
      endcase
   end

   // Strobe history for edge detection
   always @(posedge clk)
   begin
      if (!rst_n)
         strb_d <= `CCR_STROBES_IDLE;
      else
         strb_d <= strb_s;
   end

   // Configuration and change latches
   wire ready_toggle = ready_live_state ^ ready_q;
   wire wp_toggle    = wp_live_state ^ wp_q;
   wire prr_wr       = attr_wr && (off == `CCR_OFF_PRR);
   wire ccsr_wr      = attr_wr && (off == `CCR_OFF_CCSR);
   wire lpr_change   = ccsr_wr && (data_s[`CCR_CS_LOWPWR] != low_power_request);

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         sig_chg_en         <= 1'b0;
         byte_io_sel        <= 1'b0;
         pl1_disable        <= 1'b0;  // RQ6
         audio_en           <= 1'b0;
         low_power_request  <= 1'b0;
         ready_change_latch <= 1'b0;
         wp_change_latch    <= 1'b0;
         drive_num          <= 1'b0;
         ready_q            <= 1'b1;
         wp_q               <= 1'b0;
      end
      else
      begin
         ready_q <= ready_live_state;
         wp_q    <= wp_live_state;
         if (ccsr_wr)
         begin
            sig_chg_en        <= data_s[`CCR_CS_CHANGE_SIGNAL_ENABLE];
            byte_io_sel       <= data_s[`CCR_CS_BYTEIO];  // RQ5
            if (PL1_SUPPORT != 0)
               pl1_disable    <= data_s[`CCR_CS_PL1DIS];  // RQ6
            audio_en          <= data_s[`CCR_CS_AUDIO];
            low_power_request <= data_s[`CCR_CS_LOWPWR];  // RQ7
         end
         if (attr_wr && (off == `CCR_OFF_SCR))
            drive_num <= data_s[`CCR_SC_DRIVE];  // RQ15
         // A toggle in the same cycle as a host clear still sets
         if (ready_toggle)
            ready_change_latch <= 1'b1;  // RQ11
         else if (prr_wr && data_s[`CCR_PR_RDY_MASK])
            ready_change_latch <= data_s[`CCR_PR_RDY_CHG];  // RQ14
         if (wp_toggle)
            wp_change_latch <= 1'b1;  // RQ11
         else if (prr_wr && data_s[`CCR_PR_WP_MASK])
            wp_change_latch <= data_s[`CCR_PR_WP_CHG];  // RQ14
      end
   end

   // Power state: busy through every requested transition
   wire bus_busy = !s_ce1_n || !s_ce2_n || cmd_arrive;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         pstate <= PS_ACTIVE;
         ptimer <= 32'h0;
      end
      else if (lpr_change)
      begin
         pstate <= data_s[`CCR_CS_LOWPWR] ? PS_TO_DOWN : PS_TO_UP;  // RQ7
         ptimer <= 32'h0;
      end
      else
      begin
         case (pstate)
            PS_ACTIVE:
            begin
               if (bus_busy)
                  ptimer <= 32'h0;
               else if (ptimer >= IDLE_W - 32'h1)
               begin
                  pstate <= PS_DOWN;  // RQ8
                  ptimer <= 32'h0;
               end
               else
                  ptimer <= ptimer + 32'h1;
            end
            PS_TO_DOWN, PS_TO_UP:
            begin
               if (ptimer >= SETTLE_W - 32'h1)
               begin
                  pstate <= (pstate == PS_TO_DOWN) ? PS_DOWN : PS_ACTIVE;  // RQ7
                  ptimer <= 32'h0;
               end
               else
                  ptimer <= ptimer + 32'h1;
            end
            PS_DOWN:
            begin
               ptimer <= 32'h0;
               if (cmd_arrive)
                  pstate <= PS_TO_UP;  // RQ8
            end
            default:
            begin
               pstate <= PS_ACTIVE;
               ptimer <= 32'h0;
            end
         endcase
      end
   end

   // Pin outputs and read data, all registered
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         data_out          <= 16'h0000;
         data_oe_n         <= 2'b11;
         iois16_n          <= 1'b1;
         wait_n            <= 1'b1;
         status_change_pin <= 1'b1;
         ready_irq_pin     <= 1'b1;
         power_down        <= 1'b0;
         drive_select_bit  <= 1'b0;
      end
      else
      begin
         power_down       <= (pstate == PS_DOWN);
         drive_select_bit <= drive_num;
         status_change_pin <= !(io_mode && changed && sig_chg_en);  // RQ4
         ready_irq_pin    <= io_mode ? !irq_request : ready_live_state;
         iois16_n         <= !(io_sel && (!s_iord_n || !s_iowr_n));  // RQ19
         wait_n           <= !(io_rd && !io_data_ready);  // RQ21
         if (attr_rd)
         begin
            data_out  <= {8'h00, attr_rdata};  // RQ25
            data_oe_n <= 2'b10;
         end
         else if (io_rd)
         begin
            data_out  <= {io_odd_rdata, lo_odd ? io_odd_rdata : io_even_rdata};  // RQ22 RQ23
            data_oe_n <= {!lane_hi, !lane_lo};  // RQ23
         end
         else
         begin
            data_out  <= 16'h0000;
            data_oe_n <= 2'b11;
         end
      end
   end

   // I/O strobes to the task file, one cycle each
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         io_rd_even      <= 1'b0;
         io_rd_odd       <= 1'b0;
         io_wr_even      <= 1'b0;
         io_wr_odd       <= 1'b0;
         io_wr_even_data <= 8'h00;
         io_wr_odd_data  <= 8'h00;
      end
      else
      begin
         io_rd_even <= io_rd_start && lane_lo && !lo_odd;  // RQ22 RQ23
         io_rd_odd  <= io_rd_start && (lane_hi || lo_odd);
         io_wr_even <= io_wr_end && lane_lo && !lo_odd;
         io_wr_odd  <= io_wr_end && (lane_hi || lo_odd);
         if (io_wr_end)
         begin
            io_wr_even_data <= data_s[7:0];
            io_wr_odd_data  <= lane_hi ? data_s[15:8] : data_s[7:0];  // RQ23
         end
      end
   end

endmodule

`default_nettype wire

/* ccr_checker.sv */
/* Port-level timing checks for the card register bank.
   Assumes a bind into ccr_card_regs, one clock, synchronous active-low reset. */
`default_nettype none
module ccr_checker (
   // Clock and reset
   input wire       clk,
   input wire       rst_n,
   // Socket side
   input wire       oe_n,
   input wire       iord_n,
   input wire [1:0] data_oe_n,
   input wire       iois16_n,
   input wire       wait_n,
   input wire       status_change_pin,
   input wire       ready_irq_pin,
   // Internal side
   input wire [5:0] config_index,
   input wire       irq_request,
   input wire       cmd_arrive,
   input wire       io_data_ready,
   input wire       io_rd_even,
   input wire       io_rd_odd,
   input wire       power_down
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_down_cmd;
      cmd_arrive && power_down;
   endsequence
   // At least eight busy cycles, then ready again within six more
   sequence s_busy;
      !ready_irq_pin [*8] ##[1:6] ready_irq_pin;
   endsequence
   a_wake_cmd: assert property (s_down_cmd |-> ##[1:15] !power_down)
      else $error("no wake after command");
   a_ready_busy: assert property (config_index == 6'h00 && $fell(ready_irq_pin) |-> s_busy)
      else $error("busy period wrong");
   a_mem_status_change_pin: assert property (config_index == 6'h00 && $past(config_index) == 6'h00 |-> status_change_pin)
      else $error("status pin low in memory mode");
   a_io_irqpin: assert property (config_index != 6'h00 && $past(config_index) != 6'h00
      |-> ready_irq_pin == !$past(irq_request))
      else $error("irq pin wrong");
   a_rd_iois: assert property (io_rd_even || io_rd_odd |-> !iois16_n)
      else $error("width strobe missing");
   a_rd_pulse: assert property (io_rd_even || io_rd_odd |=> !(io_rd_even || io_rd_odd))
      else $error("read strobe too long");
   a_even_lane: assert property (io_rd_even |-> !data_oe_n[0])
      else $error("even byte not on low lane");
   a_idle_float: assert property ((oe_n && iord_n) [*6] |-> data_oe_n == 2'b11)
      else $error("lanes driven while idle");
   a_wait_ready: assert property (io_data_ready [*2] |-> wait_n)
      else $error("wait held after data ready");
endmodule
`default_nettype wire

/* ccr_defs.vh */
/*
 * Constants of the card configuration register bank: attribute offsets,
 * field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// Clock and timing
`define CCR_CLK_NS          100
`define CCR_SETTLE_NS       1000
`define CCR_SETTLE_CYC      ((`CCR_SETTLE_NS + `CCR_CLK_NS - 1) / `CCR_CLK_NS)
`define CCR_IDLE_US         5000
`define CCR_IDLE_CYC        (`CCR_IDLE_US * 1000 / `CCR_CLK_NS)

// Attribute decode: base 200h, registers in A3..A0
`define CCR_BASE_HI         7'h20
`define CCR_OFF_CCSR        4'h2
`define CCR_OFF_PRR         4'h4
`define CCR_OFF_SCR         4'h6

// Config/status fields
`define CCR_CS_CHANGED      7
`define CCR_CS_CHANGE_SIGNAL_ENABLE       6
`define CCR_CS_BYTEIO       5
`define CCR_CS_PL1DIS       4
`define CCR_CS_AUDIO        3
`define CCR_CS_LOWPWR       2
`define CCR_CS_IRQ          1

// Pin replacement fields
`define CCR_PR_RDY_CHG      5
`define CCR_PR_WP_CHG       4
`define CCR_PR_RDY_LIVE     1
`define CCR_PR_WP_LIVE      0
`define CCR_PR_RDY_MASK     1
`define CCR_PR_WP_MASK      0
`define CCR_PR_FIXED_ONES   2'h3

// Socket/copy fields
`define CCR_SC_DRIVE        4

// Reset values
`define CCR_RST_BYTE        8'h00
`define CCR_RST_INDEX       6'h00
`define CCR_STROBES_IDLE    7'h7f

`endif

/* ccr_host.sv */
/* Host socket controller model: attribute and I/O cycles on the strobes.
   Assumes the bench calls cyc one at a time; strobes change at falling edges. */
`default_nettype none
module ccr_host (
   // Clock and card status
   input  wire logic  clk,
   input  wire logic  wait_n,
   // Strobes, address, data
   output var  logic        reg_n,
   output var  logic        ce1_n,
   output var  logic        ce2_n,
   output var  logic        oe_n,
   output var  logic        we_n,
   output var  logic        iord_n,
   output var  logic        iowr_n,
   output var  logic [10:0] addr,
   output var  logic [15:0] data_in,
   output var  logic  tmo
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {reg_n, ce2_n, ce1_n, oe_n, we_n, iord_n, iowr_n} = 7'h7f;
      addr = 11'h000;
      data_in = 16'h0000;
      tmo = 1'b0;
   end
   // k: 0 attribute read, 1 attribute write, 2 I/O read, 3 I/O write
   task automatic cyc(input logic [1:0] k, input logic [2:0] s, input logic [10:0] a, input logic [15:0] d);
      int n;
      @(negedge clk);
      {reg_n, ce2_n, ce1_n} = s;
      addr = a;
      data_in = d;
      @(negedge clk);
      {oe_n, we_n, iord_n, iowr_n} = ~(4'h8 >> k);
      repeat (5) @(negedge clk);
      for (n = 0; n < 40 && !wait_n; n++) @(negedge clk);
      if (n == 40) tmo = 1'b1;
      @(negedge clk);
      {oe_n, we_n, iord_n, iowr_n} = 4'hf;
      // Address and data held until the synced write edge is taken
      repeat (4) @(negedge clk);
      {reg_n, ce2_n, ce1_n} = 3'h7;
      data_in = ~d;
      repeat (2) @(negedge clk);
   endtask
endmodule
`default_nettype wire

/* ccr_sync.v */
/*
 * Two-stage synchroniser, one generate entry per bit.
 * Assumes bits are independent levels; the first stage feeds only the second.
 */
`default_nettype none

module ccr_sync #(
   parameter             WIDTH = 1,
   parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Data
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         reg stage1;
         reg stage2;
         always @(posedge clk)
         begin
            if (!rst_n)
            begin
               stage1 <= INIT[i];
               stage2 <= INIT[i];
            end
            else
            begin
               stage1 <= async_in[i];
               stage2 <= stage1;
            end
         end
         assign sync_out[i] = stage2;
      end
   endgenerate

endmodule

`default_nettype wire

/* tb_top.sv */
/* Self-checking bench for ccr_card_regs with a host model and queued expectations.
   Assumes ccr_host and ccr_checker are compiled alongside. */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, tmo;
   logic [10:0] addr;
   logic [15:0] data_in, data_out, m;
   logic [1:0]  data_oe_n, prev_oe = 2'b11;
   logic        iois16_n, wait_n, status_change_pin, ready_irq_pin, irq_request, irq_enable_n, cmd_arrive;
   logic        io_data_ready, io_rd_even, io_rd_odd, io_wr_even, io_wr_odd, drive_select_bit, power_down;
   logic [5:0]  config_index;
   logic [7:0]  io_even_rdata, io_odd_rdata, io_wr_even_data, io_wr_odd_data;
   logic [17:0] rq[$], wq[$], e;
   int          failures, check_count, i;
   logic [2:0]  sel[5] = '{3'b000, 3'b010, 3'b010, 3'b001, 3'b100};
   logic        a0s[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   ccr_host host_i (.*);
   ccr_card_regs #(.IDLE_CYCLES(20), .PL1_SUPPORT(0)) ccr_card_regs_i (.*);
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [17:0] ex, input logic [17:0] got);
      check_count++;
      if (got !== ex)
      begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, ex, got);
      end
   endtask
   task end_sim;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task tchk;
      if (host_i.tmo)
      begin
         failures++;
         end_sim;
      end
   endtask
   task ar(input logic [3:0] o, input logic [7:0] v);
      rq.push_back({10'h200, v});
      host_i.cyc(2'd0, 3'b010, {7'h20, o}, 16'h0000);
      tchk;
   endtask
   task aw(input logic [3:0] o, input logic [7:0] v);
      host_i.cyc(2'd1, 3'b010, {7'h20, o}, {8'($urandom), v});
      tchk;
   endtask
   task automatic io(input logic [2:0] s, input logic a0, input logic live);
      logic [15:0] d;
      logic        pe, po;
      d = 16'($urandom);
      io_even_rdata = 8'($urandom);
      io_odd_rdata = 8'($urandom);
      pe = !s[0] && (!s[1] || !a0);
      po = !s[1] || (!s[0] && a0);
      if (live) rq.push_back({s[1:0], s[1] ? 8'h00 : io_odd_rdata,
                              s[0] ? 8'h00 : (s[1] && a0 ? io_odd_rdata : io_even_rdata)});
      host_i.cyc(2'd2, s, {10'($urandom), a0}, 16'h0000);
      tchk;
      if (live) wq.push_back({pe, po, po ? (s[1] ? d[7:0] : d[15:8]) : 8'h00, pe ? d[7:0] : 8'h00});
      host_i.cyc(2'd3, s, {10'($urandom), a0}, d);
      tchk;
   endtask
   task wt(input logic v);
      int n;
      for (n = 0; n < 80 && power_down !== v; n++) @(negedge clk);
      chk({17'h0, v}, {17'h0, power_down});
      if (power_down !== v) end_sim;
   endtask
   // Result watcher: lanes turning on, or a write strobe
   always @(negedge clk)
   begin
      if (data_oe_n !== 2'b11 && prev_oe === 2'b11)
      begin
         e = rq.size() ? rq.pop_front() : 18'h3ffff;
         m = {{8{~e[17]}}, {8{~e[16]}}};
         chk(e, {data_oe_n, data_out & m});
      end
      prev_oe = data_oe_n;
      if ((io_wr_even | io_wr_odd) !== 1'b0)
      begin
         e = wq.size() ? wq.pop_front() : 18'h0;
         chk(e, {io_wr_even, io_wr_odd, io_wr_odd_data & {8{io_wr_odd}}, io_wr_even_data & {8{io_wr_even}}});
      end
   end
   always @(negedge clk) io_data_ready <= iord_n ? 1'b0 : (io_data_ready | ($urandom_range(3) == 0));
   initial
   begin
      {rst_n, cmd_arrive, irq_request} = 3'h0;
      irq_enable_n = 1'b1;
      config_index = 6'h00;
      {io_even_rdata, io_odd_rdata} = 16'h0000;
      failures = 0;
      check_count = 0;
      void'($urandom(32'h25726c74));
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      wt(1'b1);
      cmd_arrive = 1'b1;
      @(negedge clk);
      cmd_arrive = 1'b0;
      wt(1'b0);
      repeat (15) @(negedge clk);
      $display("test power done");
      ar(4'h2, 8'h80);
      ar(4'h4, 8'h2e);
      aw(4'h4, 8'h30);
      ar(4'h4, 8'h2e);
      aw(4'h4, 8'h02);
      ar(4'h4, 8'h0e);
      aw(4'h2, 8'hfb);
      ar(4'h2, 8'h68);
      aw(4'h2, 8'h6c);
      ar(4'h4, 8'h2c);
      repeat (15) @(negedge clk);
      ar(4'h2, 8'hec);
      aw(4'h2, 8'h68);
      repeat (15) @(negedge clk);
      aw(4'h4, 8'h02);
      irq_request = 1'b1;
      irq_enable_n = 1'b0;
      ar(4'h2, 8'h6a);
      irq_enable_n = 1'b1;
      ar(4'h2, 8'h68);
      irq_request = 1'b0;
      aw(4'h4, 8'h13);
      ar(4'h4, 8'h1e);
      ar(4'h2, 8'he8);
      ar(4'h8, 8'h00);
      host_i.cyc(2'd0, 3'b010, 11'h203, 16'h0000);
      host_i.cyc(2'd0, 3'b010, 11'h602, 16'h0000);
      $display("test registers done");
      aw(4'h6, 8'h1f);
      ar(4'h6, 8'h10);
      chk(18'h1, {17'h0, drive_select_bit});
      for (i = 0; i < 5; i++) io(sel[i], a0s[i], 1'b0);
      config_index = 6'h01;
      repeat (4) @(negedge clk);
      chk(18'h0, {17'h0, status_change_pin});
      aw(4'h2, 8'h28);
      repeat (4) @(negedge clk);
      chk(18'h1, {17'h0, status_change_pin});
      irq_request = 1'b1;
      repeat (4) @(negedge clk);
      chk(18'h0, {17'h0, ready_irq_pin});
      irq_request = 1'b0;
      for (i = 0; i < 5; i++) io(sel[i], a0s[i], !sel[i][2]);
      repeat (10) @(negedge clk);
      chk(18'h0, 18'(rq.size() + wq.size()));
      $display("test io done");
      end_sim;
   end
endmodule
bind ccr_card_regs ccr_checker ccr_checker_i (.*);
`default_nettype wire
